// ===== hdl/rva_pkg.sv
`default_nettype none
package rva_pkg;
  // ---------------------------------------------
  // Widths and sources
  // ---------------------------------------------
  localparam int unsigned PC_W = 12;
  localparam int unsigned SRC_N = 20;
  localparam int unsigned NUM_W = 5;
  // Reset address with the fuse unprogrammed
  localparam logic [11:0] RESET_ADDR_APP = 12'h000;
  // Offset from the table start to the first request vector
  localparam logic [11:0] VEC_FIRST_OFS = 12'h001;
  // Request line index; base vector is index plus VEC_FIRST_OFS
  localparam logic [4:0] SRC_EXT_REQUEST_0 = 5'h00;
  localparam logic [4:0] SRC_EXT_REQUEST_1 = 5'h01;
  localparam logic [4:0] SRC_TMR2_COMPARE = 5'h02;
  localparam logic [4:0] SRC_TMR2_OVERFLOW = 5'h03;
  localparam logic [4:0] SRC_TMR1_CAPTURE = 5'h04;
  localparam logic [4:0] SRC_TMR1_COMPARE_A = 5'h05;
  localparam logic [4:0] SRC_TMR1_COMPARE_B = 5'h06;
  localparam logic [4:0] SRC_TMR1_OVERFLOW = 5'h07;
  localparam logic [4:0] SRC_TMR0_OVERFLOW = 5'h08;
  localparam logic [4:0] SRC_SPI_TRANSFER_DONE = 5'h09;
  localparam logic [4:0] SRC_USART_RECEIVE_DONE = 5'h0a;
  localparam logic [4:0] SRC_USART_DATA_EMPTY = 5'h0b;
  localparam logic [4:0] SRC_USART_TRANSMIT_DONE = 5'h0c;
  localparam logic [4:0] SRC_ADC_DONE = 5'h0d;
  localparam logic [4:0] SRC_NV_DATA_READY = 5'h0e;
  localparam logic [4:0] SRC_ANALOG_COMPARATOR_EVENT = 5'h0f;
  localparam logic [4:0] SRC_TWO_WIRE_IFACE = 5'h10;
  localparam logic [4:0] SRC_EXT_REQUEST_2 = 5'h11;
  localparam logic [4:0] SRC_TMR0_COMPARE = 5'h12;
  localparam logic [4:0] SRC_PROGRAM_STORE_READY = 5'h13;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
  localparam logic [1:0] SYNC_WAIT_CYC = 2'h2;
  // ---------------------------------------------
  // Carriers
  // ---------------------------------------------
  typedef struct packed {
    logic wr;
    logic vector_change_enable;
    logic vector_select_bit;
  } rva_ctl_wr_type;
  typedef struct packed {
    logic reset_load;
    logic irq_take;
    logic [4:0] irq_num;
    logic [11:0] addr;
  } rva_pc_req_type;
  typedef enum logic [2:0] {
    ST_SYNC = 3'b001,
    ST_BOOT = 3'b010,
    ST_RUN = 3'b100
  } rva_state_type;
endpackage
`default_nettype wire

// ===== hdl/rva_vector.sv
// Notes on behaviour
// - Fuse unprogrammed: after any reset, execution starts at address zero.
// - Fuse programmed: after reset, execution starts at the boot reset address.
// - Select bit set: each vector is its base address plus boot start.
// - Reset start follows the fuse alone; table start follows the select bit alone.
// - External requests 0, 1, 2 use bases 0x001, 0x002, 0x012.
// - Timer requests use bases 0x003 through 0x009 and 0x013.
// - Serial requests use bases 0x00A through 0x00D and 0x011.
// - ADC, data memory, comparator, store ready use 0x00E, 0x00F, 0x010, 0x014.
// - A vector is fetched only for an enabled, requesting source.
// - Select changes only by enable write then select write within four cycles.
// - Requests masked during the change sequence; global flag untouched.
`timescale 1ns/1ps
`default_nettype none
module rva_vector (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic boot_reset_fuse,
  input wire logic [rva_pkg::PC_W-1:0] boot_start_addr,
  input wire logic [rva_pkg::SRC_N-1:0] irq_pending,
  input wire logic global_irq_flag,
  input wire logic core_irq_ready,
  input wire logic insn_done,
  input wire rva_pkg::rva_ctl_wr_type ctl_wr,
  output rva_pkg::rva_pc_req_type pc_req,
  output logic vector_select_bit,
  output logic irq_masked
);
  import rva_pkg::*;

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  logic fuse_meta_reg, fuse_reg;
  logic [PC_W-1:0] boot_meta_reg, boot_reg;

  // Two stages for the fuse and boot start straps
  // Straps are static levels from before release, so the word needs no handshake
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fuse_meta_reg <= 1'b1;
      fuse_reg <= 1'b1;
      boot_meta_reg <= 12'h000;
      boot_reg <= 12'h000;
    end else begin
      fuse_meta_reg <= boot_reset_fuse;
      fuse_reg <= fuse_meta_reg;
      boot_meta_reg <= boot_start_addr;
      boot_reg <= boot_meta_reg;
    end
  end

  // ---------------------------------------------
  // Start-up sequence
  // ---------------------------------------------
  rva_state_type state_reg;
  logic [1:0] wait_reg;

  // Wait for the straps to settle, then load the reset address once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_SYNC;
      wait_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_SYNC: begin
          wait_reg <= wait_reg + 2'h1;
          if (wait_reg == SYNC_WAIT_CYC - 2'h1) begin
            state_reg <= ST_BOOT;
          end
        end
        ST_BOOT: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_SYNC;
      endcase
    end
  end

  // ---------------------------------------------
  // Vector table relocation control
  // ---------------------------------------------
  logic [2:0] window_reg;
  logic hold_reg;
  logic in_window;
  assign in_window = (window_reg != 3'h0);

  // Enable write opens the window; select write inside it takes effect
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      window_reg <= 3'h0;
      vector_select_bit <= 1'b0;
    end else if (ctl_wr.wr && ctl_wr.vector_change_enable) begin
      window_reg <= CHANGE_WINDOW_CYC;
    end else if (ctl_wr.wr && in_window) begin
      vector_select_bit <= ctl_wr.vector_select_bit;
      window_reg <= 3'h0;
    end else if (in_window) begin
      window_reg <= window_reg - 3'h1;
    end
  end

  // After the select write, mask until the next instruction finishes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= 1'b0;
    end else if (ctl_wr.wr && !ctl_wr.vector_change_enable && in_window) begin
      hold_reg <= 1'b1;
    end else if (insn_done) begin
      hold_reg <= 1'b0;
    end
  end

  // Masking flag, registered: set in the cycle after the enabling write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_masked <= 1'b0;
    end else begin
      irq_masked <= (ctl_wr.wr && ctl_wr.vector_change_enable) || (window_reg > 3'h1) ||
        (ctl_wr.wr && in_window) || (hold_reg && !insn_done);
    end
  end

  // ---------------------------------------------
  // Request selection and address generation
  // ---------------------------------------------
  logic [NUM_W-1:0] win_num;
  logic any_req;
  logic masked_now;
  logic take_now;
  logic [PC_W-1:0] table_base;
  logic [PC_W-1:0] boot_target;

  // Lowest numbered pending request wins
  always_comb begin
    win_num = 5'h00;
    any_req = 1'b0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (irq_pending[i]) begin
        win_num = 5'(i);
        any_req = 1'b1;
      end
    end
  end

  assign masked_now = irq_masked || (ctl_wr.wr && ctl_wr.vector_change_enable) || in_window || hold_reg;
  // Only enabled, pending sources ever reach a fetch
  assign take_now = (state_reg == ST_RUN) && any_req && global_irq_flag && core_irq_ready &&
    !masked_now && !pc_req.irq_take;
  assign table_base = vector_select_bit ? boot_reg : RESET_ADDR_APP;
  assign boot_target = fuse_reg ? RESET_ADDR_APP : boot_reg;

  // Program counter load requests to the core
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_req <= '0;
    end else begin
      pc_req.reset_load <= (state_reg == ST_BOOT);
      pc_req.irq_take <= take_now;
      if (state_reg == ST_BOOT) begin
        pc_req.addr <= boot_target;
        pc_req.irq_num <= 5'h00;
      end else if (take_now) begin
        pc_req.addr <= table_base + VEC_FIRST_OFS + {7'h00, win_num};
        pc_req.irq_num <= win_num;
      end
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_enable_wr;
    ctl_wr.wr && ctl_wr.vector_change_enable;
  endsequence
  sequence s_quiet4;
    !ctl_wr.wr [*4];
  endsequence

  a_reset_addr_app: assert property ($rose(pc_req.reset_load) && fuse_reg |-> pc_req.addr == 12'h000)
    else $error("reset load not at zero");
  a_reset_addr_boot: assert property ($rose(pc_req.reset_load) && !fuse_reg |-> pc_req.addr == boot_reg)
    else $error("reset load not at boot address");
  a_vector_reloc: assert property (pc_req.irq_take && $past(vector_select_bit) |->
    pc_req.addr == boot_reg + 12'h001 + {7'h00, pc_req.irq_num})
    else $error("relocated vector wrong");
  a_vector_plain: assert property (pc_req.irq_take && !$past(vector_select_bit) |->
    pc_req.addr == 12'h001 + {7'h00, pc_req.irq_num})
    else $error("base vector wrong");
  a_ext2_base: assert property (pc_req.irq_take && pc_req.irq_num == SRC_EXT_REQUEST_2 &&
    !$past(vector_select_bit) |-> pc_req.addr == 12'h012)
    else $error("request 2 vector wrong");
  a_store_ready_base: assert property (pc_req.irq_take && pc_req.irq_num == SRC_PROGRAM_STORE_READY &&
    !$past(vector_select_bit) |-> pc_req.addr == 12'h014)
    else $error("store ready vector wrong");
  a_take_cause: assert property (pc_req.irq_take |-> |($past(irq_pending) & (20'h00001 << pc_req.irq_num)) &&
    $past(global_irq_flag))
    else $error("vector without enabled request");
  a_lowest_wins: assert property (pc_req.irq_take |-> ($past(irq_pending) & ((20'h00001 << pc_req.irq_num) -
    20'h00001)) == 20'h00000)
    else $error("lower request skipped");
  a_select_guard: assert property (!in_window && !(ctl_wr.wr && ctl_wr.vector_change_enable) |=>
    $stable(vector_select_bit))
    else $error("select changed outside sequence");
  a_mask_window: assert property (s_enable_wr ##1 s_quiet4 |-> ##1 !irq_masked || hold_reg)
    else $error("masking outlasts four cycles");
  a_mask_start: assert property (s_enable_wr |=> irq_masked ##1 !pc_req.irq_take)
    else $error("not masked after enable");
  // Select write inside the window lands on the next edge
  a_select_take: assert property (ctl_wr.wr && !ctl_wr.vector_change_enable && in_window |=>
    vector_select_bit == $past(ctl_wr.vector_select_bit))
    else $error("select write inside window lost");
  // A vector load is a single-cycle pulse
  a_take_pulse: assert property (pc_req.irq_take |=> !pc_req.irq_take)
    else $error("vector taken twice in a row");
  // Masking holds while the select hold waits for an instruction
  a_hold_masks: assert property (hold_reg && !insn_done |=> irq_masked)
    else $error("hold without masking");
endmodule // rva_vector
`default_nettype wire

// ===== dv/rva_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: takes vectors, then stays busy briefly
module rva_core_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic irq_take,
  input wire logic step,
  output logic core_irq_ready,
  output logic insn_done
);
  logic [1:0] stall_reg;
  // Busy for two cycles after each vector is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stall_reg <= 2'h0;
    end else if (irq_take) begin
      stall_reg <= 2'h2;
    end else if (stall_reg != 2'h0) begin
      stall_reg <= stall_reg - 2'h1;
    end
  end
  assign core_irq_ready = resetn && (stall_reg == 2'h0) && !irq_take;
  // One completion pulse for each step request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      insn_done <= 1'b0;
    end else begin
      insn_done <= step;
    end
  end
endmodule // rva_core_model
`default_nettype wire

// ===== dv/test_reset_and_vector_addressing.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_vector_addressing;
  import rva_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, fuse = 1'b1, flag = 1'b1, step = 1'b0;
  logic [11:0] boot = 12'hc00;
  logic [19:0] pend = 20'h0;
  logic rdy, done, vsel, masked;
  rva_ctl_wr_type ctl = '0;
  rva_pc_req_type pc;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #50 clk_sys = ~clk_sys;
  rva_vector rva_vector_inst (.clk_sys(clk_sys), .resetn(resetn), .boot_reset_fuse(fuse),
    .boot_start_addr(boot), .irq_pending(pend), .global_irq_flag(flag), .core_irq_ready(rdy),
    .insn_done(done), .ctl_wr(ctl), .pc_req(pc), .vector_select_bit(vsel), .irq_masked(masked));
  rva_core_model rva_core_model_inst (.clk_sys(clk_sys), .resetn(resetn), .irq_take(pc.irq_take),
    .step(step), .core_irq_ready(rdy), .insn_done(done));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Reset with a fuse setting, then check the reset load address
  task automatic do_reset(input logic f, input logic [11:0] exp);
    int i;
    @(posedge clk_sys);
    resetn <= 1'b0;
    fuse <= f;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    for (i = 0; i < 10 && pc.reset_load !== 1'b1; i++) tick(1);
    chk(pc.reset_load, 1'b1);
    chk(pc.addr, exp);
    chk(vsel, 1'b0);
  endtask
  // Raise requests and expect one vector take
  task automatic take(input logic [19:0] p, input logic [4:0] n, input logic [11:0] a);
    int i;
    @(posedge clk_sys);
    pend <= p;
    #1;
    for (i = 0; i < 12 && pc.irq_take !== 1'b1; i++) tick(1);
    chk(pc.irq_take, 1'b1);
    chk(pc.irq_num, n);
    chk(pc.addr, a);
    @(posedge clk_sys);
    pend <= 20'h0;
    tick(2);
  endtask
  task automatic ctl_write(input logic en, input logic sel);
    @(posedge clk_sys);
    ctl <= '{wr: 1'b1, vector_change_enable: en, vector_select_bit: sel};
    @(posedge clk_sys);
    ctl <= '0;
    #1;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_table(input logic [11:0] base);
    for (int i = 0; i < 20; i++) take(20'h1 << i, i[4:0], base + 12'h001 + i[11:0]);
  endtask
  task automatic t_gating();
    @(posedge clk_sys);
    flag <= 1'b0;
    pend <= 20'h00100;
    tick(6);
    chk(pc.irq_take, 1'b0);
    chk(pc.addr, 12'h014);
    @(posedge clk_sys);
    flag <= 1'b1;
    pend <= 20'h0;
    take(20'h0a010, 5'h04, 12'h005);
  endtask
  task automatic t_relocate();
    ctl_write(1'b1, 1'b0);
    chk(masked, 1'b1);
    ctl_write(1'b0, 1'b1);
    chk(vsel, 1'b1);
    @(posedge clk_sys);
    pend <= 20'h00004;
    tick(6);
    chk(pc.irq_take, 1'b0);
    chk(pc.addr, 12'h005);
    chk(masked, 1'b1);
    @(posedge clk_sys);
    step <= 1'b1;
    @(posedge clk_sys);
    step <= 1'b0;
    take(20'h00004, 5'h02, 12'hc03);
    ctl_write(1'b0, 1'b0);
    tick(6);
    chk(vsel, 1'b1);
    ctl_write(1'b1, 1'b0);
    chk(masked, 1'b1);
    tick(5);
    chk(masked, 1'b0);
    chk(vsel, 1'b1);
  endtask
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc >= 6000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    do_reset(1'b1, 12'h000);
    t_table(12'h000);
    t_gating();
    t_relocate();
    t_table(12'hc00);
    do_reset(1'b0, 12'hc00);
    take(20'h80000, 5'h13, 12'h014);
    final_report();
  end
endmodule // test_reset_and_vector_addressing
`default_nettype wire
